// ===== verilog/ccr_codec_regs.sv
// Control register bank, serial control port, PCM slot engine and buzzer PWM of the voice codec
//
// What this block does
// - Two range bits pick standard, halved or doubled tone; fourth code forbidden.
// - Buzzer enable bit 7 gates the buzzer output; disabled after power-on.
// - Bit 6 says whether duty counts the high part or the low part.
// - Six-bit duty code is an unsigned binary number, MSB first.
// - Buzzer is PWM at tone f1, duty equals code times 0.78125 percent.
// - Disabled or powered down, buzzer rests at the duty polarity level.
// - Tone frequency is code over 0.128, 0.256 or 0.064 hertz by range.
// - Bits 7 and 6 pick the divider for 512k, 1.536M, 2.048M, 2.56M clocks.
// - Bit 5 picks 14-bit linear (default) or 8-bit companded PCM.
// - Bits 4 and 3 pick companding law, or linear number format.
// - Bit 2 places channel slots back to back or two bits apart.
// - Seven-bit mode ignores received LSB and floats transmit LSB.
// - Loopback returns received slot byte unprocessed, amplifiers muted.
// - Timing bits pick delayed, non-delayed normal or non-delayed reverse framing.
// - Latch pin shows the inverse of the written latch bit.
// - Receive injection decodes the host byte; reading gives the received byte.
// - Transmit injection sends the host byte every frame instead of encoder.
// - Layout, seven-bit, slot choice and injections act only when companded.
// - PCM bytes move most significant bit first on both sides.
// - Companded full-scale codes follow the selected law exactly.
// - Voice transfer disabled by default: no decoding, transmit slots floating.
// - Slot choice bit picks first (default) or second channel slot.
// - Sidetone is forced off whenever the transmit path is disabled.
// - Each access is a command byte then one data byte.
`timescale 1ns/1ps
`include "ccr_defs.svh"

module ccr_codec_regs
  import ccr_pkg::*;
#(
  parameter int CLK_HZ = 25000000
) (
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  // Serial control port from the host
  input  wire logic            ctl_sclk,
  input  wire logic            ctl_cs_n,
  input  wire logic            ctl_din,
  output logic                 ctl_dout,
  output logic                 ctl_dout_oe,
  // PCM port
  input  wire logic            pcm_bclk,
  input  wire logic            pcm_fs,
  input  wire logic            pcm_dr,
  output logic                 pcm_dx,
  output logic                 pcm_dx_oe,
  // Master clock pin and internal filter tick
  input  wire logic            mclk,
  output logic                 filt_tick,
  // Codec core side
  input  wire logic [13:0]     enc_linear,
  input  ccr_comp_t            enc_comp,
  input  wire logic [7:0]      tone_f1_code,
  input  wire logic            power_down,
  output logic [13:0]          dec_linear,
  output ccr_comp_t            dec_comp,
  output logic                 dec_valid,
  // Configuration outputs to the analog side
  output ccr_clk_coding_t      coding_cfg,
  output ccr_audio_t           audio_cfg,
  output logic                 sidetone_on,
  output logic                 amp_mute,
  output logic                 latch_pin,
  output logic                 buzzer_out
);

  localparam int NPIN = 7;
  localparam int P_SCLK = 0;
  localparam int P_CS = 1;
  localparam int P_DIN = 2;
  localparam int P_BCLK = 3;
  localparam int P_FS = 4;
  localparam int P_DR = 5;
  localparam int P_MCLK = 6;

  // Registers
  ccr_pcm_if_t      pcm_cfg;
  ccr_buzzer_t      buz_cfg;
  logic [1:0]       tone_range;
  logic [7:0]       rx_inject_byte;
  logic [7:0]       tx_inject_byte;

  // Pin synchronisers
  logic [NPIN-1:0]  pin_s1;
  logic [NPIN-1:0]  pin_s2;
  logic [NPIN-1:0]  pin_s3;
  logic [NPIN-1:0]  pin_lvl;
  logic [NPIN-1:0]  pin_prev;
  logic [NPIN-1:0]  pin_rise;
  logic [NPIN-1:0]  pin_fall;

  // Control port state
  ccr_ctl_state_t   ctl_state;
  logic [4:0]       ctl_cnt;
  logic [7:0]       ctl_shift;
  logic [7:0]       ctl_cmd;
  logic [7:0]       rd_shift;
  logic             wr_commit;

  // PCM state
  logic [5:0]       bit_pos;
  logic [5:0]       next_bit_pos;
  logic             fs_last;
  logic             fs_last2;
  logic [13:0]      tx_word;
  logic [13:0]      next_tx_word;
  logic [13:0]      tx_src;
  logic [13:0]      rx_shift;
  logic [13:0]      rx_word;
  logic             rx_done;
  logic [5:0]       slot_start;
  logic [5:0]       slot_len;
  logic [5:0]       slot_idx;
  logic             in_slot;
  logic             comp_mode;
  logic             tx_edge;
  logic             rx_edge;
  logic             frame_start;

  // Tone and divider state
  logic [15:0]      tone_acc;
  logic [15:0]      tone_thresh;
  logic [6:0]       pwm_phase;
  logic [3:0]       mclk_cnt;
  logic [3:0]       mclk_ratio;

  function automatic logic [7:0] comp_encode(input logic [1:0] law, input ccr_comp_t c);
    logic [7:0] code;
    code = {c.sign, c.mag};
    unique case (law)
      `CCR_LAW_MU:      comp_encode = {c.sign, ~c.mag};
      `CCR_LAW_A_INV:   comp_encode = code ^ `CCR_ALAW_INV_MASK;
      `CCR_LAW_A_PLAIN: comp_encode = code;
      default:          comp_encode = {c.sign, ~c.mag};
    endcase
  endfunction : comp_encode

  function automatic ccr_comp_t comp_decode(input logic [1:0] law, input logic [7:0] b);
    logic [7:0] code;
    code = b;
    unique case (law)
      `CCR_LAW_MU:      code = {b[7], ~b[6:0]};
      `CCR_LAW_A_INV:   code = b ^ `CCR_ALAW_INV_MASK;
      `CCR_LAW_A_PLAIN: code = b;
      default:          code = {b[7], ~b[6:0]};
    endcase
    comp_decode = code;
  endfunction : comp_decode

  // Two's complement in, chosen linear format out; decoding is the inverse
  function automatic logic [13:0] lin_convert(input logic [1:0] fmt, input logic [13:0] x, input logic to_line);
    logic [13:0] mag;
    mag = 14'(-x);
    lin_convert = x;
    if (x[13]) begin
      unique case (fmt)
        `CCR_LAW_A_INV:   lin_convert = to_line ? 14'(x - 14'h0001) : 14'(x + 14'h0001);
        `CCR_LAW_A_PLAIN: lin_convert = to_line ? {1'b1, mag[12:0]} : 14'(-{1'b0, x[12:0]});
        default:          lin_convert = x;
      endcase
    end
  endfunction : lin_convert

  assign comp_mode = coding_cfg.coding_select;

  // Three-stage sampling; a level changes once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          // Chip select idles high; a low start would look like a selection
          pin_s1[gi]   <= 1'(gi == P_CS);
          pin_s2[gi]   <= 1'(gi == P_CS);
          pin_s3[gi]   <= 1'(gi == P_CS);
          pin_lvl[gi]  <= 1'(gi == P_CS);
          pin_prev[gi] <= 1'(gi == P_CS);
        end else begin
          pin_s1[gi]   <= (gi == P_CS) ? ctl_cs_n :
                          (gi == P_SCLK) ? ctl_sclk :
                          (gi == P_DIN) ? ctl_din :
                          (gi == P_BCLK) ? pcm_bclk :
                          (gi == P_FS) ? pcm_fs :
                          (gi == P_DR) ? pcm_dr : mclk;
          pin_s2[gi]   <= pin_s1[gi];
          pin_s3[gi]   <= pin_s2[gi];
          if (pin_s2[gi] == pin_s3[gi]) begin
            pin_lvl[gi] <= pin_s3[gi];
          end
          pin_prev[gi] <= pin_lvl[gi];
        end
      end
      assign pin_rise[gi] = pin_lvl[gi] & ~pin_prev[gi];
      assign pin_fall[gi] = ~pin_lvl[gi] & pin_prev[gi];
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctl_state   <= CCR_CTL_IDLE;
      ctl_cnt     <= 5'h00;
      ctl_shift   <= 8'h00;
      ctl_cmd     <= 8'h00;
      rd_shift    <= 8'h00;
      wr_commit   <= 1'b0;
      ctl_dout    <= 1'b0;
      ctl_dout_oe <= 1'b0;
    end else begin
      wr_commit <= 1'b0;
      if (pin_lvl[P_CS]) begin
        ctl_state   <= CCR_CTL_IDLE;
        ctl_cnt     <= 5'h00;
        ctl_dout_oe <= 1'b0;
      end else begin
        unique case (ctl_state)
          CCR_CTL_IDLE: begin
            ctl_state <= CCR_CTL_CMD;
          end
          CCR_CTL_CMD: begin
            if (pin_rise[P_SCLK]) begin
              ctl_shift <= {ctl_shift[6:0], pin_lvl[P_DIN]};
              ctl_cnt   <= ctl_cnt + 5'h01;
              if (ctl_cnt == `CCR_CTL_CMD_BITS - 5'h01) begin
                ctl_cmd   <= {ctl_shift[6:0], pin_lvl[P_DIN]};
                rd_shift  <= rd_value({ctl_shift[2:0], pin_lvl[P_DIN]});
                ctl_state <= CCR_CTL_DATA;
              end
            end
          end
          CCR_CTL_DATA: begin
            if (pin_fall[P_SCLK] && ctl_cmd[`CCR_CMD_READ_BIT] && ctl_cnt < `CCR_CTL_ALL_BITS) begin
              ctl_dout    <= rd_shift[7];
              ctl_dout_oe <= 1'b1;
              rd_shift    <= {rd_shift[6:0], 1'b0};
            end
            if (pin_rise[P_SCLK] && ctl_cnt < `CCR_CTL_ALL_BITS) begin
              ctl_shift <= {ctl_shift[6:0], pin_lvl[P_DIN]};
              ctl_cnt   <= ctl_cnt + 5'h01;
              if (ctl_cnt == `CCR_CTL_ALL_BITS - 5'h01) begin
                wr_commit <= ~ctl_cmd[`CCR_CMD_READ_BIT];
              end
            end
          end
        endcase
      end
    end
  end

  function automatic logic [7:0] rd_value(input logic [3:0] addr);
    unique case (addr)
      `CCR_ADDR_CLK_CODING: rd_value = coding_cfg;
      `CCR_ADDR_PCM_IF:     rd_value = pcm_cfg;
      `CCR_ADDR_RX_SLOT:    rd_value = rx_word[13:6];
      `CCR_ADDR_AUDIO:      rd_value = audio_cfg;
      `CCR_ADDR_TONE_RANGE: rd_value = {6'h00, tone_range};
      `CCR_ADDR_BUZZER:     rd_value = buz_cfg;
      default:              rd_value = 8'h00;
    endcase
  endfunction : rd_value

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      coding_cfg     <= `CCR_RST_CLK_CODING;
      pcm_cfg        <= `CCR_RST_PCM_IF;
      audio_cfg      <= `CCR_RST_AUDIO;
      tone_range     <= 2'(`CCR_RST_TONE_RANGE);
      buz_cfg        <= `CCR_RST_BUZZER;
      rx_inject_byte <= `CCR_RST_SLOT;
      tx_inject_byte <= `CCR_RST_SLOT;
    end else if (wr_commit) begin
      unique case (ctl_cmd[`CCR_CMD_ADDR_MSB:0])
        `CCR_ADDR_CLK_CODING: coding_cfg     <= ctl_shift;
        `CCR_ADDR_PCM_IF:     pcm_cfg        <= ctl_shift;
        `CCR_ADDR_RX_SLOT:    rx_inject_byte <= ctl_shift;
        `CCR_ADDR_TX_SLOT:    tx_inject_byte <= ctl_shift;
        `CCR_ADDR_AUDIO:      audio_cfg      <= ctl_shift;
        `CCR_ADDR_TONE_RANGE: tone_range     <= ctl_shift[1:0];
        `CCR_ADDR_BUZZER:     buz_cfg        <= ctl_shift;
        default:              ;
      endcase
    end
  end

  // sidetone needs a live transmit path
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      latch_pin   <= 1'b1;
      sidetone_on <= 1'b0;
      amp_mute    <= 1'b0;
    end else begin
      latch_pin   <= ~pcm_cfg.latch_drive;
      sidetone_on <= audio_cfg.sidetone_enable & pcm_cfg.voice_enable & (|audio_cfg.tx_input_sel);
      amp_mute    <= coding_cfg.loopback_select;
    end
  end

  // master clock divider to a fixed internal rate
  always_comb begin
    unique case (coding_cfg.clock_div_sel)
      2'h0:    mclk_ratio = `CCR_DIV_512K;
      2'h1:    mclk_ratio = `CCR_DIV_1536K;
      2'h2:    mclk_ratio = `CCR_DIV_2048K;
      default: mclk_ratio = `CCR_DIV_2560K;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mclk_cnt  <= 4'h0;
      filt_tick <= 1'b0;
    end else begin
      filt_tick <= 1'b0;
      if (pin_rise[P_MCLK]) begin
        if (mclk_cnt >= mclk_ratio - 4'h1) begin
          mclk_cnt  <= 4'h0;
          filt_tick <= 1'b1;
        end else begin
          mclk_cnt <= mclk_cnt + 4'h1;
        end
      end
    end
  end

  // reverse timing swaps the launch and capture edges
  assign tx_edge = pcm_cfg.timing_mode_hi & pcm_cfg.timing_mode_lo ? pin_fall[P_BCLK] : pin_rise[P_BCLK];
  assign rx_edge = pcm_cfg.timing_mode_hi & pcm_cfg.timing_mode_lo ? pin_rise[P_BCLK] : pin_fall[P_BCLK];
  // delayed framing starts one bit after sync
  assign frame_start = pcm_cfg.timing_mode_hi ? (pin_lvl[P_FS] & ~fs_last) : (fs_last & ~fs_last2);

  always_comb begin
    next_bit_pos = bit_pos;
    if (frame_start) begin
      next_bit_pos = 6'h00;
    end else if (bit_pos != `CCR_BITPOS_IDLE) begin
      next_bit_pos = bit_pos + 6'h01;
    end
  end

  // slot options only in companded mode
  // second slot two bits later in the spaced layout
  always_comb begin
    slot_len   = comp_mode ? `CCR_COMP_BITS : `CCR_LIN_BITS;
    slot_start = 6'h00;
    if (comp_mode && pcm_cfg.slot_choice) begin
      slot_start = coding_cfg.channel_layout ? `CCR_SLOT2_GAP : `CCR_SLOT2_BACK;
    end
    slot_idx = 6'(bit_pos - slot_start);
    in_slot  = (bit_pos >= slot_start) && (bit_pos < 6'(slot_start + slot_len));
  end

  // Word of the coming frame; its first bit leaves at frame start, not the stale word
  always_comb begin
    if (coding_cfg.loopback_select) begin
      next_tx_word = rx_word;
    end else if (comp_mode && pcm_cfg.host_tx_inject) begin
      next_tx_word = {tx_inject_byte, 6'h00};
    end else if (comp_mode) begin
      // law mapping sets the full-scale codes
      next_tx_word = {comp_encode({coding_cfg.law_select, coding_cfg.inversion_select}, enc_comp), 6'h00};
    end else begin
      next_tx_word = lin_convert({coding_cfg.law_select, coding_cfg.inversion_select}, enc_linear, 1'b1);
    end
    tx_src = frame_start ? next_tx_word : tx_word;
  end

  // Transmit launch
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bit_pos   <= `CCR_BITPOS_IDLE;
      fs_last   <= 1'b0;
      fs_last2  <= 1'b0;
      tx_word   <= 14'h0000;
      pcm_dx    <= 1'b0;
      pcm_dx_oe <= 1'b0;
    end else if (tx_edge) begin
      fs_last  <= pin_lvl[P_FS];
      fs_last2 <= fs_last;
      bit_pos  <= next_bit_pos;
      if (frame_start) begin
        tx_word <= next_tx_word;
      end
    end else if (rx_edge || bit_pos == `CCR_BITPOS_IDLE) begin
      pcm_dx    <= pcm_dx;
      pcm_dx_oe <= pcm_dx_oe & (bit_pos != `CCR_BITPOS_IDLE);
    end
    if (rst_n && tx_edge) begin
      pcm_dx <= tx_src[4'(13 - slot_idx_n(next_bit_pos))];
      // slots float while voice is off
      pcm_dx_oe <= pcm_cfg.voice_enable && slot_hit(next_bit_pos) &&
                   !(comp_mode && coding_cfg.seven_bit_mode && slot_idx_n(next_bit_pos) == `CCR_COMP_BITS - 6'h01);
    end
  end

  function automatic logic [5:0] slot_idx_n(input logic [5:0] pos);
    slot_idx_n = 6'(pos - slot_start);
  endfunction : slot_idx_n

  function automatic logic slot_hit(input logic [5:0] pos);
    slot_hit = (pos >= slot_start) && (pos < 6'(slot_start + slot_len));
  endfunction : slot_hit

  // Receive capture, MSB first
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_shift <= 14'h0000;
      rx_word  <= 14'h0000;
      rx_done  <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (rx_edge && in_slot) begin
        if (comp_mode && coding_cfg.seven_bit_mode && slot_idx == `CCR_COMP_BITS - 6'h01) begin
          rx_shift <= {rx_shift[12:0], 1'b0};
        end else begin
          rx_shift <= {rx_shift[12:0], pin_lvl[P_DR]};
        end
        if (slot_idx == slot_len - 6'h01) begin
          rx_done <= 1'b1;
          if (comp_mode) begin
            rx_word <= {rx_shift[6:0], (coding_cfg.seven_bit_mode ? 1'b0 : pin_lvl[P_DR]), 6'h00};
          end else begin
            rx_word <= {rx_shift[12:0], pin_lvl[P_DR]};
          end
        end
      end
    end
  end

  // Decoder feed
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dec_linear <= 14'h0000;
      dec_comp   <= 8'h00;
      dec_valid  <= 1'b0;
    end else begin
      dec_valid <= rx_done & pcm_cfg.voice_enable & ~coding_cfg.loopback_select;
      if (rx_done) begin
        if (comp_mode) begin
          // host byte replaces the line data
          dec_comp <= comp_decode({coding_cfg.law_select, coding_cfg.inversion_select},
                                  pcm_cfg.host_rx_inject ? rx_inject_byte : rx_word[13:6]);
        end else begin
          dec_linear <= lin_convert({coding_cfg.law_select, coding_cfg.inversion_select}, rx_word, 1'b0);
        end
      end
    end
  end

  // step length per code unit scales with range
  always_comb begin
    unique case (tone_range)
      `CCR_RANGE_HALF:   tone_thresh = 16'(CLK_HZ / `CCR_MS_PER_S * `CCR_TONE_STEP_MS * 2);
      `CCR_RANGE_DOUBLE: tone_thresh = 16'(CLK_HZ / `CCR_MS_PER_S * `CCR_TONE_STEP_MS / 2);
      default:           tone_thresh = 16'(CLK_HZ / `CCR_MS_PER_S * `CCR_TONE_STEP_MS);
    endcase
  end

  // 128 phase steps per tone period
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tone_acc  <= 16'h0000;
      pwm_phase <= 7'h00;
    end else if (16'(tone_acc + {8'h00, tone_f1_code}) >= tone_thresh) begin
      tone_acc  <= 16'(tone_acc + {8'h00, tone_f1_code} - tone_thresh);
      pwm_phase <= pwm_phase + 7'h01;
    end else begin
      tone_acc <= 16'(tone_acc + {8'h00, tone_f1_code});
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      buzzer_out <= 1'b0;
    end else if (!buz_cfg.buzzer_enable || power_down) begin
      buzzer_out <= buz_cfg.duty_polarity;
    end else begin
      buzzer_out <= buz_cfg.duty_polarity ^ (pwm_phase < {1'b0, buz_cfg.duty_code});
    end
  end

endmodule : ccr_codec_regs

// ===== common/ccr_defs.svh
// Register indices, reset values, field positions and timing constants of the codec control block
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH

// Register indices carried in the command byte
`define CCR_ADDR_CLK_CODING  4'h0
`define CCR_ADDR_PCM_IF      4'h1
`define CCR_ADDR_RX_SLOT     4'h2
`define CCR_ADDR_TX_SLOT     4'h3
`define CCR_ADDR_AUDIO       4'h4
`define CCR_ADDR_TONE_RANGE  4'hA
`define CCR_ADDR_BUZZER      4'hB

// Power-on values
`define CCR_RST_CLK_CODING   8'h00
`define CCR_RST_PCM_IF       8'h00
`define CCR_RST_SLOT         8'h00
`define CCR_RST_AUDIO        8'h00
`define CCR_RST_TONE_RANGE   8'h00
`define CCR_RST_BUZZER       8'h00

// Command byte layout and instruction length
`define CCR_CMD_READ_BIT     7
`define CCR_CMD_ADDR_MSB     3
`define CCR_CTL_CMD_BITS     5'h08
`define CCR_CTL_ALL_BITS     5'h10

// Tone range codes, two bits
`define CCR_RANGE_STD        2'h0
`define CCR_RANGE_HALF       2'h1
`define CCR_RANGE_DOUBLE     2'h2

// Law codes (law_select, inversion_select)
`define CCR_LAW_MU           2'h0
`define CCR_LAW_A_INV        2'h2
`define CCR_LAW_A_PLAIN      2'h3
`define CCR_ALAW_INV_MASK    8'h55

// Slot geometry in bit periods
`define CCR_COMP_BITS        6'h08
`define CCR_LIN_BITS         6'h0E
`define CCR_SLOT2_BACK       6'h08
`define CCR_SLOT2_GAP        6'h0A
`define CCR_BITPOS_IDLE      6'h3F

// Master clock divide ratios down to the internal filter rate
`define CCR_DIV_512K         4'h2
`define CCR_DIV_1536K        4'h6
`define CCR_DIV_2048K        4'h8
`define CCR_DIV_2560K        4'hA

// One duty step per code unit lasts this long in the standard range
`define CCR_TONE_STEP_MS     1
`define CCR_MS_PER_S         1000

`endif

// ===== common/ccr_pkg.sv
// Types shared by the codec control register block
package ccr_pkg;

  typedef struct packed {
    logic [1:0] clock_div_sel;   // hi, lo
    logic       coding_select;
    logic       law_select;
    logic       inversion_select;
    logic       channel_layout;
    logic       seven_bit_mode;
    logic       loopback_select;
  } ccr_clk_coding_t;

  typedef struct packed {
    logic       timing_mode_hi;
    logic       timing_mode_lo;
    logic       latch_drive;
    logic       host_rx_inject;
    logic       host_tx_inject;
    logic       voice_enable;
    logic       slot_choice;
    logic       reserved0;
  } ccr_pcm_if_t;

  typedef struct packed {
    logic [1:0] tx_input_sel;
    logic       sidetone_enable;
    logic [1:0] output_sel;
    logic       ring_route;
    logic       rx_hp_bypass;
    logic       rx_route;
  } ccr_audio_t;

  typedef struct packed {
    logic       buzzer_enable;
    logic       duty_polarity;
    logic [5:0] duty_code;
  } ccr_buzzer_t;

  typedef struct packed {
    logic       sign;
    logic [6:0] mag;
  } ccr_comp_t;

  typedef enum logic [2:0] {
    CCR_CTL_IDLE  = 3'b001,
    CCR_CTL_CMD   = 3'b010,
    CCR_CTL_DATA  = 3'b100
  } ccr_ctl_state_t;

endpackage : ccr_pkg

// ===== verification/ccr_pcm_far.sv
// Far-side PCM model: one frame per call, bit clock still between frames
`timescale 1ns/1ps
module ccr_pcm_far (
  // System clock and PCM pins
  input  wire logic clk_sys,
  input  wire logic pcm_dx,
  output logic      pcm_bclk,
  output logic      pcm_fs,
  output logic      pcm_dr
);
  initial {pcm_bclk, pcm_fs, pcm_dr} = 3'h0;
  task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
    for (int k = 0; k < 12; k++) begin
      repeat (10) @(posedge clk_sys) #1;
      pcm_bclk = 1'b1;
      pcm_dr = (k > 1 && k < 10) ? tx[9-k] : ~pcm_dr;
      repeat (10) @(posedge clk_sys) #1;
      pcm_bclk = 1'b0;
      pcm_fs = (k == 0);
      if (k > 1 && k < 10) rx[9-k] = pcm_dx;
    end
  endtask : frame
endmodule : ccr_pcm_far

// ===== verification/ccr_codec_regs_properties.sv
// Port assertions of the codec control block
`timescale 1ns/1ps
module ccr_codec_regs_properties
  import ccr_pkg::*;
(
  // Watched ports
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       ctl_cs_n,
  input wire logic       ctl_dout_oe,
  input wire logic       filt_tick,
  input wire logic       power_down,
  input wire logic       dec_valid,
  input ccr_clk_coding_t coding_cfg,
  input ccr_audio_t      audio_cfg,
  input wire logic       sidetone_on,
  input wire logic       amp_mute,
  input wire logic       latch_pin,
  input wire logic       buzzer_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_mute_loop: assert property (coding_cfg.loopback_select [*2] |-> amp_mute)
    else $error("no mute in loopback");
  a_loop_nodec: assert property (coding_cfg.loopback_select [*2] |-> !dec_valid)
    else $error("decode in loopback");
  a_side_off: assert property ((audio_cfg.tx_input_sel == 2'h0) [*2] |-> !sidetone_on)
    else $error("sidetone with transmit off");
  a_buz_rest: assert property (power_down [*4] |-> $stable(buzzer_out))
    else $error("buzzer moves in power down");
  a_tick_gap: assert property (filt_tick |=> !filt_tick [*3])
    else $error("filter ticks too close");
  a_dout_idle: assert property (ctl_cs_n [*6] |-> !ctl_dout_oe)
    else $error("read data driven while deselected");
  a_dec_pulse: assert property (dec_valid |=> !dec_valid)
    else $error("decode strobe too long");
  a_reset_vals: assert property ($rose(rst_n) |->
    latch_pin && !buzzer_out && coding_cfg == 8'h00 && audio_cfg == 8'h00)
    else $error("bad value after reset");
endmodule : ccr_codec_regs_properties
bind ccr_codec_regs ccr_codec_regs_properties u_ccr_codec_regs_properties (.clk_sys, .rst_n, .ctl_cs_n,
  .ctl_dout_oe, .filt_tick, .power_down, .dec_valid, .coding_cfg, .audio_cfg, .sidetone_on, .amp_mute,
  .latch_pin, .buzzer_out);

// ===== verification/tb.sv
// Testbench of the codec control block
`timescale 1ns/1ps
module tb;
  import ccr_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, mclk = 1'b0, power_down = 1'b1;
  logic ctl_sclk = 1'b0, ctl_cs_n = 1'b1, ctl_din = 1'b0;
  logic ctl_dout, ctl_dout_oe, pcm_bclk, pcm_fs, pcm_dr, pcm_dx, pcm_dx_oe;
  logic filt_tick, dec_valid, sidetone_on, amp_mute, latch_pin, buzzer_out;
  logic [7:0] tone_f1_code = 8'h00, rd, px;
  ccr_clk_coding_t coding_cfg;
  ccr_audio_t audio_cfg;
  ccr_comp_t enc_comp = 8'h00, dec_comp;
  int bad_count = 0, n_compared = 0;
  always #20 clk_sys = ~clk_sys;
  // Master clock at one tenth of the system clock rate, edges aligned to it
  always #200 mclk = ~mclk;
  ccr_codec_regs u_ccr_codec_regs (.clk_sys, .rst_n, .ctl_sclk, .ctl_cs_n, .ctl_din, .ctl_dout, .ctl_dout_oe,
    .pcm_bclk, .pcm_fs, .pcm_dr, .pcm_dx, .pcm_dx_oe, .mclk, .filt_tick, .enc_linear(14'h0000),
    .enc_comp, .tone_f1_code, .power_down, .dec_linear(), .dec_comp, .dec_valid, .coding_cfg,
    .audio_cfg, .sidetone_on, .amp_mute, .latch_pin, .buzzer_out);
  ccr_pcm_far u_ccr_pcm_far (.clk_sys, .pcm_dx(pcm_dx_oe ? pcm_dx : 1'bz), .pcm_bclk, .pcm_fs, .pcm_dr);
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys) #1;
  endtask : w
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd);
    logic [15:0] sh;
    sh = {cmd, wd};
    ctl_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      ctl_sclk = 1'b0;
      ctl_din = sh[i];
      w(6);
      if (i < 8) rd[i] = ctl_dout;
      ctl_sclk = 1'b1;
      w(6);
    end
    ctl_cs_n = 1'b1;
    ctl_sclk = 1'b0;
    w(10);
  endtask : xfer
  task automatic t_reset;
    chk("latch", 8'h01, 8'(latch_pin));
    chk("buzzer", 8'h00, 8'(buzzer_out));
    xfer(8'h8B, 8'h00);
    chk("buzzer reg", 8'h00, rd);
    $display("reset test done");
  endtask : t_reset
  task automatic t_regs;
    xfer(8'h00, 8'hA5);
    power_down = 1'b0;
    chk("coding", 8'hA5, coding_cfg);
    chk("mute", 8'h01, 8'(amp_mute));
    xfer(8'h80, 8'h00);
    chk("read 0", 8'hA5, rd);
    xfer(8'h03, 8'h5A);
    xfer(8'h83, 8'h00);
    chk("read 3", 8'h00, rd);
    xfer(8'h85, 8'h00);
    chk("read 5", 8'h00, rd);
    xfer(8'h01, 8'h20);
    chk("latch", 8'h00, 8'(latch_pin));
    xfer(8'h04, 8'h20);
    chk("sidetone", 8'h00, 8'(sidetone_on));
    xfer(8'h0A, 8'h02);
    xfer(8'h8A, 8'h00);
    chk("range", 8'h02, rd);
    $display("register test done");
  endtask : t_regs
  task automatic t_buzzer;
    int hi, ticks;
    tone_f1_code = 8'hC8;
    xfer(8'h0B, 8'hA0);
    hi = 0;
    ticks = 0;
    // One doubled-range period at quarter duty
    for (int i = 0; i < 8000; i++) begin
      w(1);
      hi += buzzer_out;
      ticks += filt_tick;
    end
    chk("duty", 8'h01, 8'(hi > 1850 && hi < 2150));
    chk("filter ticks", 8'h01, 8'(ticks >= 99 && ticks <= 101));
    power_down = 1'b1;
    w(6);
    chk("rest low", 8'h00, 8'(buzzer_out));
    power_down = 1'b0;
    xfer(8'h0B, 8'h40);
    chk("rest high", 8'h01, 8'(buzzer_out));
    $display("buzzer test done");
  endtask : t_buzzer
  task automatic t_pcm;
    xfer(8'h00, 8'h20);
    xfer(8'h03, 8'hB4);
    u_ccr_pcm_far.frame(8'h3C, px);
    chk("dx off", 8'hZZ, px);
    xfer(8'h01, 8'h0C);
    xfer(8'h04, 8'h60);
    chk("sidetone", 8'h01, 8'(sidetone_on));
    u_ccr_pcm_far.frame(8'h3C, px);
    chk("dx first", 8'hB4, px);
    u_ccr_pcm_far.frame(8'h3C, px);
    chk("dx byte", 8'hB4, px);
    xfer(8'h82, 8'h00);
    chk("rx byte", 8'h3C, rd);
    enc_comp = 8'hFF;
    xfer(8'h01, 8'h04);
    u_ccr_pcm_far.frame(8'h3C, px);
    chk("full scale", 8'h80, px);
    chk("decoded", 8'h43, dec_comp);
    $display("pcm test done");
  endtask : t_pcm
  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  initial begin
    w(10);
    rst_n = 1'b1;
    w(4);
    t_reset;
    t_regs;
    t_buzzer;
    t_pcm;
    conclude;
  end
  initial begin
    #4ms;
    bad_count++;
    conclude;
  end
endmodule : tb
